// *** bench/sadc_comp_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sadc_comp_model (
  input wire logic core_clk_in, // System clock
  input wire logic [11:0] analog_input_sel_in, // One-hot input select
  input wire logic [11:0] level_in, // Inputs held above every ladder tap
  output logic comp_out // Comparator decision
);
  logic toggle = 1'b0;
  always @(posedge core_clk_in) toggle <= ~toggle;
  // With no input selected the node floats, so the decision wanders
  always_comb comp_out = (analog_input_sel_in == 12'h000) ? toggle : |(analog_input_sel_in & level_in);
endmodule : sadc_comp_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [31:0] a_hi = sadc_pkg::ADDR_RESULT_HIGH;
  localparam logic [31:0] a_lo = sadc_pkg::ADDR_RESULT_LOW;
  localparam logic [31:0] a_md = sadc_pkg::ADDR_MODE;
  localparam logic [31:0] a_st = sadc_pkg::ADDR_START;
  localparam logic [31:0] a_ck = sadc_pkg::ADDR_CLK_STOP_1;
  localparam logic [31:0] a_is = sadc_pkg::ADDR_IRQ_STATUS;
  localparam logic [31:0] a_im = sadc_pkg::ADDR_IRQ_MASK;
  localparam logic [31:0] a_es = sadc_pkg::ADDR_EDGE_SELECT;
  logic clk, rst_n, hsel, hwrite, pin, hrdy, hresp, sh, stby, irq, comp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [11:0] sel, lvl;
  logic [7:0] rd;
  logic [9:0] res;
  logic [7:0] mdl [logic [31:0]];
  int n_mismatch = 0;
  int num_checks = 0;
  int tmo = 0;
  sadc_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hrdy), .ext_trigger_pin_in(pin),
    .comp_in(comp), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .analog_input_sel_out(sel),
    .sample_hold_out(sh), .converter_standby_out(stby), .irq_out(irq));
  sadc_comp_model cm (.core_clk_in(clk), .analog_input_sel_in(sel), .level_in(lvl), .comp_out(comp));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    tmo <= tmo + 1;
    if (tmo == 30000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // Read data is taken at the closing edge, before the slave's registered outputs move on
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (a == a_md) mdl[a] = d | 8'h30;
    if (a == a_ck) mdl[a] = d;
    if (a == a_im || a == a_es) mdl[a] = d & 8'h01;
  endtask : wr
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask : rc
  task automatic mres();
    mdl[a_md] = 8'h30;
    mdl[a_ck] = 8'hff;
    mdl[a_im] = 8'h00;
    mdl[a_es] = 8'h00;
  endtask : mres
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask : settle
  task automatic conv(input logic f, input int ch, input logic msk);
    int n;
    res = lvl[ch] ? 10'h3ff : 10'h000;
    wr(a_im, {7'h00, msk});
    wr(a_is, 8'h01);
    wr(a_md, {f, 3'b011, 4'(ch + 4)});
    wr(a_st, 8'h80);
    rc(a_st, 8'hff);
    n = 2;
    if (msk) begin
      do begin
        @(negedge clk);
        n++;
      end while (irq !== 1'b1 && n < 200);
      chk(n >= (f ? 31 : 62) && n <= (f ? 35 : 66), 1'b1);
    end else begin
      repeat (80) @(negedge clk);
      chk(irq, 1'b0);
    end
    rc(a_is, 8'h01);
    rc(a_st, 8'h7f);
    rc(a_hi, res[9:2]);
    bus(1'b0, a_lo, 8'h00);
    chk(rd[7:6], res[1:0]);
    $display("test conversion fast=%0d ch=%0d done", f, ch);
  endtask : conv
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    pin = 1'b0;
    void'($urandom(46));
    lvl = 12'($urandom);
    mres();
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rc(a_md, 8'h30);
    rc(a_st, 8'h7f);
    rc(a_ck, 8'hff);
    rc(a_is, 8'h00);
    rc(32'h0000_ffd0, 8'h00);
    wr(a_md, 8'hcf);
    rc(a_md, mdl[a_md]);
    wr(a_md, 8'h00);
    rc(a_md, mdl[a_md]);
    for (int c = 0; c < 16; c++) begin
      wr(a_md, c[7:0]);
      settle();
      chk(sel, c < 4 ? 12'h000 : 12'h001 << (c - 4));
    end
    $display("test registers done");
    conv(1'b0, 0, 1'b1);
    conv(1'b1, 11, 1'b1);
    conv(1'($urandom), $urandom_range(0, 11), 1'b0);
    wr(a_im, 8'h01);
    settle();
    chk(irq, 1'b1);
    wr(a_is, 8'h01);
    settle();
    chk(irq, 1'b0);
    for (int p = 0; p < 2; p++) begin
      pin <= p[0];
      wr(a_es, p[7:0]);
      wr(a_md, 8'h74);
      pin <= ~p[0];
      repeat (8) @(posedge clk);
      rc(a_st, 8'hff);
      wr(a_st, 8'h00);
      repeat (80) @(posedge clk);
      rc(a_is, 8'h00);
      rc(a_st, 8'h7f);
      wr(a_md, 8'h34);
      pin <= p[0];
      repeat (4) @(posedge clk);
      pin <= ~p[0];
      repeat (8) @(posedge clk);
      rc(a_st, 8'h7f);
    end
    $display("test trigger done");
    wr(a_ck, 8'hef);
    settle();
    chk(stby, 1'b1);
    rc(a_ck, mdl[a_ck]);
    wr(a_st, 8'h80);
    rc(a_st, 8'h7f);
    wr(a_ck, 8'hff);
    settle();
    chk(stby, 1'b0);
    $display("test standby done");
    conv(1'b1, 5, 1'b1);
    lvl <= ~lvl;
    repeat (20) @(posedge clk);
    rc(a_hi, res[9:2]);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    mres();
    rc(a_hi, res[9:2]);
    rc(a_md, mdl[a_md]);
    $display("test reset hold done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire

// *** design/sadc_sar_engine.sv ***
`timescale 1ns/10ps
`default_nettype none
module sadc_sar_engine (
  input wire logic core_clk_in, // System clock
  input wire logic rst_n_in, // Sync reset, active low
  input wire logic comp_in, // Comparator decision, synchronised
  sadc_sar_if.sar_m sif // Control side
);
  sadc_pkg::sadc_state_t state, next_state;
  logic [5:0] cnt, next_cnt;
  logic [5:0] total;
  logic [9:0] sar, next_sar;
  logic [3:0] bitp, next_bitp;
  logic done, next_done;

  assign sif.busy = (state == sadc_pkg::ST_CONV);
  assign sif.done = done;
  assign sif.sar = sar;
  assign sif.step = bitp;

  always_comb begin
    total = sif.fast ? sadc_pkg::CYCLES_FAST : sadc_pkg::CYCLES_SLOW;
    next_state = state;
    next_cnt = cnt;
    next_sar = sar;
    next_bitp = bitp;
    next_done = 1'b0;
    unique case (state)
      sadc_pkg::ST_IDLE: begin
        if (sif.start) begin
          next_state = sadc_pkg::ST_CONV;
          next_cnt = 6'd1;
          next_sar = 10'h200; // Trial MSB; result holds intermediates
          next_bitp = 4'd9;
        end
      end
      sadc_pkg::ST_CONV: begin
        if (sif.stop) begin
          next_state = sadc_pkg::ST_IDLE;
        end else if (cnt == total) begin
          next_state = sadc_pkg::ST_IDLE;
          next_done = 1'b1;
        end else begin
          next_cnt = cnt + 6'd1;
          // One bit decided per step while bits remain; the tail is settle time
          // Fast mode decides a bit every second clock so all ten bits fit in the shorter time
          if ((sif.fast ? (cnt[0] == 1'b0) : (cnt[1:0] == 2'd0)) && (bitp != 4'd15)) begin
            if (!comp_in) begin
              next_sar[bitp] = 1'b0;
            end
            if (bitp != 4'd0) begin
              next_sar[bitp - 4'd1] = 1'b1;
            end
            next_bitp = bitp - 4'd1;
          end
        end
      end
      default: next_state = sadc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state <= sadc_pkg::ST_IDLE;
      cnt <= 6'd0;
      bitp <= 4'd0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitp <= next_bitp;
      done <= next_done;
    end
  end

  // Approximation register has no reset so the held result survives it
  always_ff @(posedge core_clk_in) begin
    sar <= next_sar;
  end

  conv_len_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(sif.busy) && !sif.fast |-> (sif.busy && !sif.stop)[*8] ##0 1'b1)
    else $error("conversion ended too early");
endmodule : sadc_sar_engine
`default_nettype wire

// *** design/sadc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module sadc_top (
  input wire logic core_clk_in, // System clock 50 MHz
  input wire logic rst_n_in, // Sync reset, active low
  input wire logic hsel_in, // AHB select
  input wire logic [31:0] haddr_in, // AHB address
  input wire logic [1:0] htrans_in, // AHB transfer type
  input wire logic hwrite_in, // AHB write
  input wire logic [2:0] hsize_in, // AHB size
  input wire logic [31:0] hwdata_in, // AHB write data
  input wire logic hready_in, // AHB bus ready
  input wire logic ext_trigger_pin_in, // External trigger pin
  input wire logic comp_in, // Analog comparator output
  output logic [31:0] hrdata_out, // AHB read data
  output logic hreadyout_out, // AHB ready
  output logic hresp_out, // AHB response, always OKAY
  output logic [11:0] analog_input_sel_out, // One-hot analog mux select
  output logic sample_hold_out, // Sample phase active
  output logic converter_standby_out, // Module standby
  output logic irq_out // Conversion-done interrupt
);
  sadc_sar_if sif();
  logic trig_s1, trig_s2, trig_s3;
  logic comp_s1, comp_s2;
  logic [7:0] conv_mode, next_conv_mode;
  logic start_flag, next_start_flag;
  logic [7:0] module_clock_stop_1, next_module_clock_stop_1;
  logic done_req, next_done_req;
  logic done_en, next_done_en;
  logic trigger_edge_select, next_trigger_edge_select;
  logic [9:0] result, next_result;
  logic ap_valid, next_ap_valid;
  logic ap_write, next_ap_write;
  logic [31:0] ap_addr, next_ap_addr;
  logic [31:0] rdata, next_rdata;
  logic [11:0] sel, next_sel;
  logic sh, next_sh;
  logic stby, next_stby;
  logic irq, next_irq;
  logic stby_out, next_stby_out;
  logic res_valid;
  logic trig_edge;
  logic sw_write_start, sw_stop;
  logic [7:0] wbyte;

  // Pin and comparator cross into the clock domain
  always_ff @(posedge core_clk_in) begin
    trig_s1 <= ext_trigger_pin_in;
    trig_s2 <= trig_s1;
    trig_s3 <= trig_s2;
    comp_s1 <= comp_in;
    comp_s2 <= comp_s1;
  end

  // Polarity from the edge-select bit outside the converter's own registers
  assign trig_edge = trigger_edge_select ? (!trig_s2 && trig_s3) : (trig_s2 && !trig_s3);

  always_comb begin
    wbyte = hwdata_in[7:0];
    next_ap_valid = hsel_in && hready_in && htrans_in[1];
    next_ap_write = hwrite_in;
    next_ap_addr = haddr_in;
    sw_write_start = ap_valid && ap_write && (ap_addr == sadc_pkg::ADDR_START) && wbyte[sadc_pkg::START_FLAG_BIT];
    sw_stop = ap_valid && ap_write && (ap_addr == sadc_pkg::ADDR_START) && !wbyte[sadc_pkg::START_FLAG_BIT];
  end

  always_comb begin
    next_conv_mode = conv_mode;
    next_module_clock_stop_1 = module_clock_stop_1;
    next_done_en = done_en;
    next_trigger_edge_select = trigger_edge_select;
    next_done_req = done_req;
    next_start_flag = start_flag;
    if (ap_valid && ap_write) begin
      if (ap_addr == sadc_pkg::ADDR_MODE) begin
        next_conv_mode = wbyte | sadc_pkg::MODE_FIXED_ONES;
      end
      if (ap_addr == sadc_pkg::ADDR_CLK_STOP_1) begin
        next_module_clock_stop_1 = wbyte;
      end
      if (ap_addr == sadc_pkg::ADDR_IRQ_MASK) begin
        next_done_en = wbyte[0];
      end
      if (ap_addr == sadc_pkg::ADDR_EDGE_SELECT) begin
        next_trigger_edge_select = wbyte[0];
      end
      if ((ap_addr == sadc_pkg::ADDR_IRQ_STATUS) && wbyte[0]) begin
        next_done_req = 1'b0;
      end
    end
    if (sw_stop || !stby) begin
      next_start_flag = 1'b0;
    end
    if (sif.done) begin
      next_start_flag = 1'b0;
      next_done_req = 1'b1; // Set wins over the write-one clear
    end
    if (stby && (sw_write_start || (trig_edge && conv_mode[sadc_pkg::MODE_TRIG_BIT]))) begin
      next_start_flag = 1'b1;
    end
  end

  // Start pulse to the engine only from idle; a start while busy just keeps the flag
  assign sif.start = start_flag && !sif.busy && !sif.done;
  assign sif.stop = !start_flag;
  assign sif.fast = conv_mode[sadc_pkg::MODE_SPEED_BIT];

  always_comb begin
    next_result = result;
    if (sif.busy || sif.done) begin
      next_result = sif.sar;
    end
  end

  always_comb begin
    next_sel = '0;
    unique case (conv_mode[3:2])
      2'b00: next_sel = '0;
      2'b01: next_sel[{2'b00, conv_mode[1:0]}] = 1'b1;
      2'b10: next_sel[{2'b01, conv_mode[1:0]}] = 1'b1;
      2'b11: next_sel[{2'b10, conv_mode[1:0]}] = 1'b1;
    endcase
    next_sh = sif.busy && (sif.step == 4'd9);
    next_stby = module_clock_stop_1[sadc_pkg::STANDBY_BIT];
    next_stby_out = !next_stby;
    next_irq = next_done_req && next_done_en;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (next_ap_valid && !hwrite_in) begin
      unique case (haddr_in)
        sadc_pkg::ADDR_RESULT_HIGH: next_rdata = {24'h00_0000, next_result[9:2]};
        sadc_pkg::ADDR_RESULT_LOW: next_rdata = {24'h00_0000, next_result[1:0], 6'h00};
        sadc_pkg::ADDR_MODE: next_rdata = {24'h00_0000, next_conv_mode};
        sadc_pkg::ADDR_START: next_rdata = {24'h00_0000, next_start_flag, sadc_pkg::START_RESERVED[6:0]};
        sadc_pkg::ADDR_CLK_STOP_1: next_rdata = {24'h00_0000, next_module_clock_stop_1};
        sadc_pkg::ADDR_IRQ_STATUS: next_rdata = {31'h0000_0000, next_done_req};
        sadc_pkg::ADDR_IRQ_MASK: next_rdata = {31'h0000_0000, next_done_en};
        sadc_pkg::ADDR_EDGE_SELECT: next_rdata = {31'h0000_0000, next_trigger_edge_select};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      conv_mode <= sadc_pkg::MODE_RESET;
      start_flag <= 1'b0;
      module_clock_stop_1 <= sadc_pkg::CLK_STOP_RESET;
      done_req <= 1'b0;
      done_en <= 1'b0;
      trigger_edge_select <= 1'b0;
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
      sel <= 12'h000;
      sh <= 1'b0;
      stby <= 1'b1;
      stby_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      conv_mode <= next_conv_mode;
      start_flag <= next_start_flag;
      module_clock_stop_1 <= next_module_clock_stop_1;
      done_req <= next_done_req;
      done_en <= next_done_en;
      trigger_edge_select <= next_trigger_edge_select;
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
      rdata <= next_rdata;
      sel <= next_sel;
      sh <= next_sh;
      stby <= next_stby;
      stby_out <= next_stby_out;
      irq <= next_irq;
    end
  end

  // Result kept through reset
  always_ff @(posedge core_clk_in) begin
    result <= next_result;
  end

  // Marks that a finished result exists, so the hold check skips the undefined power-up value
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      res_valid <= 1'b0;
    end else if (sif.done) begin
      res_valid <= 1'b1;
    end
  end

  assign hrdata_out = rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign analog_input_sel_out = sel;
  assign sample_hold_out = sh;
  assign converter_standby_out = stby_out;
  assign irq_out = irq;

  sadc_sar_engine u_engine (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .comp_in(comp_s2),
    .sif(sif)
  );

  mode_fixed_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    conv_mode[5:4] == 2'b11)
    else $error("reserved mode bits not one");
  done_clears_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sif.done |=> !start_flag && done_req)
    else $error("done did not clear flag or set request");
  irq_gate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    irq |-> done_en && done_req)
    else $error("interrupt without enabled request");
  trig_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !start_flag && !conv_mode[sadc_pkg::MODE_TRIG_BIT] && !(ap_valid && ap_write) |=> !start_flag)
    else $error("trigger started while disabled");
  result_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    res_valid && !sif.busy && !sif.done |=> $stable(result))
    else $error("result changed while idle");
  chan_none_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    conv_mode[3:2] == 2'b00 |=> sel == 12'h000)
    else $error("channel selected for empty group");
  stby_stop_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !stby |=> !start_flag)
    else $error("conversion in standby");
endmodule : sadc_top
`default_nettype wire

// *** pkg/sadc_pkg.sv ***
// Operation
// - The 10-bit result is split into a high byte with the eight upper bits and bits 7:6 of a low byte with the two lower bits.
// - Result registers are readable at any time but their content during a conversion is not meaningful.
// - When a conversion finishes the result is stored and held until the next conversion starts.
// - Reset does not clear the result registers.
// - The mode register resets to 0x30: slow speed, trigger off, reserved ones, no channel.
// - Speed bit 0 gives a 62 clock conversion and speed bit 1 gives 31 clocks.
// - Trigger pin edges start a conversion only while the trigger enable bit is one.
// - The trigger edge polarity comes from an edge-select bit outside the converter registers.
// - Mode bits 5 and 4 always read one and ignore writes.
// - Channel field upper bits 00 select nothing, 01 inputs 0-3, 10 inputs 4-7, 11 inputs 8-11, lower bits index.
// - Writing one to the start flag starts, it reads one while busy, clears itself on completion, and writing zero stops.
// - Completion sets the done request flag and an interrupt is raised only when its enable is set.
// - An enabled trigger edge sets the start flag just like a software start.
// - Clearing the standby control bit puts the converter in standby, setting it (reset value) releases it.
package sadc_pkg;
  // Register indices; each register takes one aligned word, so the byte address is four times the index
  localparam logic [31:0] IDX_RESULT_HIGH = 32'h0000_ffc4;
  localparam logic [31:0] IDX_RESULT_LOW = 32'h0000_ffc5;
  localparam logic [31:0] IDX_MODE = 32'h0000_ffc6;
  localparam logic [31:0] IDX_START = 32'h0000_ffc7;
  localparam logic [31:0] IDX_CLK_STOP_1 = 32'h0000_fffa;
  localparam logic [31:0] IDX_IRQ_STATUS = 32'h0000_ffc8;
  localparam logic [31:0] IDX_IRQ_MASK = 32'h0000_ffc9;
  localparam logic [31:0] IDX_EDGE_SELECT = 32'h0000_ffca;
  localparam logic [31:0] ADDR_RESULT_HIGH = IDX_RESULT_HIGH << 2;
  localparam logic [31:0] ADDR_RESULT_LOW = IDX_RESULT_LOW << 2;
  localparam logic [31:0] ADDR_MODE = IDX_MODE << 2;
  localparam logic [31:0] ADDR_START = IDX_START << 2;
  localparam logic [31:0] ADDR_CLK_STOP_1 = IDX_CLK_STOP_1 << 2;
  localparam logic [31:0] ADDR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
  localparam logic [31:0] ADDR_IRQ_MASK = IDX_IRQ_MASK << 2;
  localparam logic [31:0] ADDR_EDGE_SELECT = IDX_EDGE_SELECT << 2;
  localparam logic [7:0] MODE_RESET = 8'h30;
  localparam logic [7:0] MODE_FIXED_ONES = 8'h30;
  localparam logic [7:0] START_RESERVED = 8'h7f;
  localparam logic [7:0] CLK_STOP_RESET = 8'hff;
  localparam int MODE_SPEED_BIT = 7;
  localparam int MODE_TRIG_BIT = 6;
  localparam int START_FLAG_BIT = 7;
  localparam int STANDBY_BIT = 4;
  localparam int LOW_RESULT_SHIFT = 6;
  localparam logic [5:0] CYCLES_SLOW = 6'h3e;
  localparam logic [5:0] CYCLES_FAST = 6'h1f;
  localparam int RESULT_W = 10;
  localparam int SAR_STEP_CYCLES = 3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } sadc_state_t;
endpackage : sadc_pkg

// *** pkg/sadc_sar_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface sadc_sar_if;
  logic start;
  logic stop;
  logic fast;
  logic busy;
  logic done;
  logic [9:0] sar;
  logic [3:0] step;
  modport ctrl (output start, output stop, output fast, input busy, input done, input sar, input step);
  modport sar_m (input start, input stop, input fast, output busy, output done, output sar,
    output step);
endinterface : sadc_sar_if
`default_nettype wire
